// File: design/sysmgmt_memory_control_ctl.sv
`timescale 1ns/1ps
`default_nettype none
`include "sysmgmt_memory_control_ctl_cfg.svh"

// What this block does
// - graphics field 00 off, 01 on no memory, 10 on 512K, 11 on 1M
// - graphics off: clocks stopped, no memory taken, legacy video to hub
// - graphics on: non-management legacy video accesses served internally, memory reserved for codes 10 and 11
// - graphics field only counts outside external card mode; writes still land in it
// - top segment taken at top of memory, graphics memory just below
// - upper field: 00 off, 01 remap only, 10 top 512KB, 11 top 1MB
// - top segment spans top minus size to top, management-mode processor only
// - legacy segment remapped at high window, only while lower field is 00
// - non-management accesses to enabled upper segments go to the hub
// - lower field 00 keeps segment from DRAM, 01 makes it plain RAM
// - lower field 10: only management-mode processor code reads reach DRAM
// - lower field 11: all management-mode processor accesses reach DRAM
// - lock freezes lock, graphics, upper field, bit 3; bit 2 needs bit 3
// - lock set by ordinary write, cleared only by reset
// - lock also freezes the two DRAM parameter registers
// - error flag set on non-management processor upper segment hit, not write-backs
// - error flag cleared by writing one, zero writes ignored
// - reserved memory is excluded from general system RAM
module sysmgmt_memory_control_ctl (
    // clock and reset
    input  wire logic                      clk_in,
    input  wire logic                      sys_rst_in,
    // configuration space port
    input  wire logic                      cfg_wr_in,
    input  wire logic                      cfg_rd_in,
    input  wire logic [7:0]                cfg_addr_in,
    input  wire logic [7:0]                cfg_wdata_in,
    output logic      [7:0]                cfg_rdata_out,
    // platform state
    input  wire logic                      ext_card_mode_in,
    input  wire logic [31:0]               top_of_memory_in,
    // processor access decode
    input  wire logic                      acc_valid_in,
    input  wire sysmgmt_memory_control_ctl_pkg::acc_req_t   acc_in,
    output logic                           ans_valid_out,
    output sysmgmt_memory_control_ctl_pkg::acc_ans_t        ans_out,
    // status towards the rest of the bridge
    output logic                           gfx_enable_out,
    output logic                           gfx_clk_en_out,
    output logic [31:0]                    sysram_top_out,
    output logic [31:0]                    gfx_base_out,
    output logic [31:0]                    top_segment_base_out,
    output logic                           dram_regs_locked_out
);
    import sysmgmt_memory_control_ctl_pkg::*;

    // control byte fields
    logic [1:0] graphics_mem_select;
    logic [1:0] upper_segment_select;
    logic [1:0] lower_segment_select;
    logic       space_lock;
    logic       ext_access_err_flag;

    wire logic [7:0]  sysmgmt_memory_control;
    wire logic        cfg_hit;
    wire logic        cfg_write;
    wire logic [1:0]  next_gms;
    wire logic [1:0]  next_useg;
    wire logic        next_lseg_hi;
    wire logic        next_lseg_lo;
    wire logic        next_lock;
    wire logic        next_err;
    wire logic        err_set;
    wire logic        err_clr;

    assign sysmgmt_memory_control = {graphics_mem_select, upper_segment_select,
                                     lower_segment_select, space_lock, ext_access_err_flag};

    // register write decode
    assign cfg_hit   = (cfg_addr_in == `SMC_CFG_OFFSET);
    assign cfg_write = cfg_wr_in && cfg_hit;

    assign next_gms     = (cfg_write && !space_lock) ?
                          cfg_wdata_in[`SMC_GMS_HI:`SMC_GMS_LO] : graphics_mem_select;
    assign next_useg    = (cfg_write && !space_lock) ?
                          cfg_wdata_in[`SMC_USEG_HI:`SMC_USEG_LO] : upper_segment_select;
    assign next_lseg_hi = (cfg_write && !space_lock) ?
                          cfg_wdata_in[`SMC_LSEG_HI] : lower_segment_select[1];
    // bit 2 stays open under lock only while bit 3 is one
    assign next_lseg_lo = (cfg_write && (!space_lock || lower_segment_select[1])) ?
                          cfg_wdata_in[`SMC_LSEG_LO] : lower_segment_select[0];

    assign next_lock = space_lock || (cfg_write && cfg_wdata_in[`SMC_LOCK_BIT]);

    assign err_clr  = cfg_write && cfg_wdata_in[`SMC_ERR_BIT];
    // a fresh violation in the clearing cycle is kept, set beats clear
    assign next_err = err_set || (ext_access_err_flag && !err_clr);

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            {graphics_mem_select, upper_segment_select, lower_segment_select,
             space_lock, ext_access_err_flag} <= `SMC_RESET_VALUE;
        end else begin
            graphics_mem_select  <= next_gms;
            upper_segment_select <= next_useg;
            lower_segment_select <= {next_lseg_hi, next_lseg_lo};
            space_lock           <= next_lock;
            ext_access_err_flag  <= next_err;
        end
    end

    // read data, unmatched offsets read as zero
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cfg_rdata_out <= 8'h00;
        end else begin
            cfg_rdata_out <= (cfg_rd_in && cfg_hit) ? sysmgmt_memory_control : 8'h00;
        end
    end

    // ---- memory layout ----
    wire logic        gfx_on;
    wire logic [31:0] gfx_size;
    wire logic [31:0] top_segment_size;
    wire logic [31:0] top_segment_base;
    wire logic [31:0] gfx_base;
    wire logic        high_remap_on;

    assign gfx_on = (graphics_mem_select != 2'b00) && !ext_card_mode_in;

    assign gfx_size = !gfx_on                       ? `SMC_SIZE_NONE :
                      (graphics_mem_select == 2'b10) ? `SMC_SIZE_512K :
                      (graphics_mem_select == 2'b11) ? `SMC_SIZE_1M   : `SMC_SIZE_NONE;

    assign top_segment_size = (upper_segment_select == 2'b10) ? `SMC_SIZE_512K :
                              (upper_segment_select == 2'b11) ? `SMC_SIZE_1M   : `SMC_SIZE_NONE;

    assign top_segment_base = top_of_memory_in - top_segment_size;
    assign gfx_base         = top_segment_base - gfx_size;

    // remap only with lower field 00
    assign high_remap_on = (upper_segment_select != 2'b00) && (lower_segment_select == 2'b00);

    // ---- address windows ----
    wire logic ab_hit;
    wire logic high_remap_segment_hit;
    wire logic top_segment_hit;
    wire logic gfx_hit;
    wire logic below_tom;

    addr_window u_ab (
        .en_in   (1'b1),
        .base_in (`SMC_AB_BASE),
        .size_in (`SMC_AB_SIZE),
        .addr_in (acc_in.addr),
        .hit_out (ab_hit)
    );

    addr_window u_high_remap_segment (
        .en_in   (high_remap_on),
        .base_in (`SMC_HIGH_REMAP_SEGMENT_BASE),
        .size_in (`SMC_HIGH_REMAP_SEGMENT_SIZE),
        .addr_in (acc_in.addr),
        .hit_out (high_remap_segment_hit)
    );

    addr_window u_top_segment (
        .en_in   (1'b1),
        .base_in (top_segment_base),
        .size_in (top_segment_size),
        .addr_in (acc_in.addr),
        .hit_out (top_segment_hit)
    );

    addr_window u_gfx (
        .en_in   (gfx_on),
        .base_in (gfx_base),
        .size_in (gfx_size),
        .addr_in (acc_in.addr),
        .hit_out (gfx_hit)
    );

    assign below_tom = (acc_in.addr < top_of_memory_in);

    // ---- routing ----
    wire logic   smm_cpu;
    wire logic   ab_to_dram;
    wire logic   ext_hit;
    wire route_t vga_dest;
    wire route_t next_route;
    wire logic [31:0] next_dram_addr;

    assign smm_cpu = acc_in.smm && acc_in.cpu;
    assign ext_hit = top_segment_hit || high_remap_segment_hit;

    assign ab_to_dram = (lower_segment_select == 2'b01)
                     || ((lower_segment_select == 2'b10) && smm_cpu && acc_in.code && !acc_in.write)
                     || ((lower_segment_select == 2'b11) && smm_cpu);

    assign vga_dest = gfx_on ? ROUTE_GFX : ROUTE_HUB;

    // priority: legacy, upper segments, stolen, RAM
    assign next_route = ab_hit    ? (ab_to_dram ? ROUTE_DRAM : vga_dest) :
                        ext_hit   ? (smm_cpu ? ROUTE_DRAM : ROUTE_HUB) :
                        gfx_hit   ? ROUTE_HUB :
                        below_tom ? ROUTE_DRAM : ROUTE_HUB;

    // high window lands on the legacy segment in DRAM
    assign next_dram_addr = high_remap_segment_hit ? (acc_in.addr - `SMC_HIGH_REMAP_SEGMENT_BASE + `SMC_AB_BASE)
                                     : acc_in.addr;

    assign err_set = acc_valid_in && ext_hit && acc_in.cpu && !acc_in.smm && !acc_in.wb;

    // answer one cycle after the access is presented
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ans_valid_out <= 1'b0;
            ans_out       <= '{route: ROUTE_HUB, dram_addr: 32'h0000_0000};
        end else begin
            ans_valid_out <= acc_valid_in;
            if (acc_valid_in) begin
                ans_out <= '{route: next_route, dram_addr: next_dram_addr};
            end
        end
    end

    // layout and status outputs, registered to keep timing off the decode
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            gfx_enable_out       <= 1'b0;
            gfx_clk_en_out       <= 1'b0;
            sysram_top_out       <= 32'h0000_0000;
            gfx_base_out         <= 32'h0000_0000;
            top_segment_base_out <= 32'h0000_0000;
            dram_regs_locked_out <= 1'b0;
        end else begin
            gfx_enable_out       <= gfx_on;
            gfx_clk_en_out       <= gfx_on;
            sysram_top_out       <= gfx_base;
            gfx_base_out         <= gfx_base;
            top_segment_base_out <= top_segment_base;
            dram_regs_locked_out <= space_lock;
        end
    end

    // ---- checks ----
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence lock_write_s;
        cfg_write && cfg_wdata_in[`SMC_LOCK_BIT];
    endsequence

    sequence locked_write_s;
        space_lock && cfg_write;
    endsequence

    sequence top_segment_outsider_s;
        acc_valid_in && top_segment_hit && !smm_cpu;
    endsequence

    gfx_decode_a: assert property (
        (graphics_mem_select == 2'b11 && !ext_card_mode_in && upper_segment_select == 2'b00)
        |-> (gfx_base == top_of_memory_in - `SMC_SIZE_1M))
        else $error("graphics size 1M not reserved");

    gfx_clock_off_a: assert property (
        (graphics_mem_select == 2'b00) |=> !gfx_clk_en_out && !gfx_enable_out)
        else $error("graphics clock running while disabled");

    ext_card_mode_a: assert property (
        ext_card_mode_in |-> (!gfx_on && gfx_size == `SMC_SIZE_NONE)
        ##1 (!gfx_enable_out && !gfx_clk_en_out))
        else $error("graphics active in external card mode");

    // carve order checked against the fixed sizes, not the layout adders
    stack_order_a: assert property (
        (upper_segment_select == 2'b10 && graphics_mem_select == 2'b11 && !ext_card_mode_in)
        |-> (top_segment_base == top_of_memory_in - `SMC_SIZE_512K)
            && (gfx_base == top_of_memory_in - `SMC_SIZE_512K - `SMC_SIZE_1M))
        else $error("graphics region not directly below top segment");

    top_segment_guard_a: assert property (
        top_segment_outsider_s |=> ans_valid_out && ans_out.route != ROUTE_DRAM)
        else $error("top segment reached DRAM outside management mode");

    high_remap_segment_remap_a: assert property (
        (acc_valid_in && high_remap_segment_hit && smm_cpu)
        |=> ans_out.route == ROUTE_DRAM && ans_out.dram_addr[31:17] == 15'h0005)
        else $error("high window not remapped to legacy segment");

    code_shadow_a: assert property (
        (acc_valid_in && ab_hit && lower_segment_select == 2'b10 && acc_in.write)
        |=> ans_out.route != ROUTE_DRAM)
        else $error("write reached DRAM in code shadow mode");

    lock_freeze_a: assert property (
        locked_write_s |=> $stable(graphics_mem_select) && $stable(upper_segment_select)
                           && $stable(lower_segment_select[1]))
        else $error("locked field changed");

    lock_sticky_a: assert property (
        lock_write_s |=> space_lock [*8])
        else $error("lock bit cleared without reset");

    dram_lock_a: assert property (
        lock_write_s |-> ##2 dram_regs_locked_out)
        else $error("DRAM registers not locked");

    err_set_a: assert property (
        (acc_valid_in && ext_hit && acc_in.cpu && !acc_in.smm && !acc_in.wb)
        |=> ext_access_err_flag)
        else $error("error flag not set on outsider access");

    err_clear_a: assert property (
        (ext_access_err_flag && err_clr && !err_set) |=> !ext_access_err_flag)
        else $error("error flag not cleared by one write");

endmodule // sysmgmt_memory_control_ctl

`default_nettype wire

// File: design/sysmgmt_memory_control_ctl_cfg.svh
`ifndef SYSMGMT_MEMORY_CONTROL_CTL_CFG_SVH
`define SYSMGMT_MEMORY_CONTROL_CTL_CFG_SVH

// configuration space location and reset image
`define SMC_CFG_OFFSET    8'h70
`define SMC_RESET_VALUE   8'h00

// field positions inside the control byte
`define SMC_GMS_HI        7
`define SMC_GMS_LO        6
`define SMC_USEG_HI       5
`define SMC_USEG_LO       4
`define SMC_LSEG_HI       3
`define SMC_LSEG_LO       2
`define SMC_LOCK_BIT      1
`define SMC_ERR_BIT       0

// sizes taken from the top of memory
`define SMC_SIZE_NONE     32'h0000_0000
`define SMC_SIZE_512K     32'h0008_0000
`define SMC_SIZE_1M       32'h0010_0000

// legacy video segment and its high remap window
`define SMC_AB_BASE       32'h000a_0000
`define SMC_AB_SIZE       32'h0002_0000
`define SMC_HIGH_REMAP_SEGMENT_BASE     32'hfeea_0000
`define SMC_HIGH_REMAP_SEGMENT_SIZE     32'h0002_0000

`endif

// File: design/sysmgmt_memory_control_ctl_pkg.sv
package sysmgmt_memory_control_ctl_pkg;

    // destination of one processor access, one-hot
    typedef enum logic [2:0] {
        ROUTE_DRAM = 3'b001,
        ROUTE_GFX  = 3'b010,
        ROUTE_HUB  = 3'b100
    } route_t;

    // one processor memory access
    typedef struct packed {
        logic [31:0] addr;
        logic        write;
        logic        code;   // instruction fetch
        logic        smm;    // issued in system management mode
        logic        cpu;    // initiator is the processor
        logic        wb;     // explicit write-back cycle
    } acc_req_t;

    // decoded answer for one access
    typedef struct packed {
        route_t      route;
        logic [31:0] dram_addr;
    } acc_ans_t;

endpackage : sysmgmt_memory_control_ctl_pkg

// File: design/addr_window.sv
`timescale 1ns/1ps
`default_nettype none

// hit when enabled and base <= addr < base + size; an empty window never hits
module addr_window (
    // window
    input  wire logic        en_in,
    input  wire logic [31:0] base_in,
    input  wire logic [31:0] size_in,
    // address under test
    input  wire logic [31:0] addr_in,
    output wire logic        hit_out
);

    wire logic [32:0] limit;

    // one extra bit so a window touching 4G does not wrap
    assign limit   = {1'b0, base_in} + {1'b0, size_in};
    assign hit_out = en_in && (size_in != 32'h0000_0000)
                     && (addr_in >= base_in)
                     && ({1'b0, addr_in} < limit);

endmodule // addr_window

`default_nettype wire

// File: bench/host_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

// processor side: one access per call, launched and released off the sampling edge
module host_cpu_model
    import sysmgmt_memory_control_ctl_pkg::*;
(
    // clock
    input  wire logic     clk_in,
    // access towards the decoder
    output var logic      acc_valid_out,
    output var acc_req_t  acc_out
);
    initial begin
        acc_valid_out = 1'b0;
        acc_out = '0;
    end

    // released bus shows inverted data so a stale sample is never mistaken for a hold
    task automatic issue(input acc_req_t r);
        @(negedge clk_in);
        acc_valid_out = 1'b1;
        acc_out = r;
        @(negedge clk_in);
        acc_valid_out = 1'b0;
        acc_out = ~r;
    endtask
endmodule // host_cpu_model

`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import sysmgmt_memory_control_ctl_pkg::*;
    localparam logic [31:0] TOP_OF_MEMORY = 32'h0400_0000;
    logic        clk_in = 1'b0, sys_rst_in = 1'b1, cfg_wr_in = 1'b0, cfg_rd_in = 1'b0, ext_card_mode_in = 1'b0;
    logic [7:0]  cfg_addr_in = 8'h70, cfg_wdata_in = 8'h00, cfg_rdata_out;
    logic [31:0] top_of_memory_in = TOP_OF_MEMORY, sysram_top_out, gfx_base_out, top_segment_base_out;
    logic        acc_valid_in, ans_valid_out, gfx_enable_out, gfx_clk_en_out, dram_regs_locked_out;
    acc_req_t    acc_in;
    acc_ans_t    ans_out;
    int          num_errors = 0, checks = 0;

    host_cpu_model u_host_cpu_model (.clk_in(clk_in), .acc_valid_out(acc_valid_in), .acc_out(acc_in));
    sysmgmt_memory_control_ctl u_sysmgmt_memory_control_ctl (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .cfg_wr_in(cfg_wr_in), .cfg_rd_in(cfg_rd_in),
        .cfg_addr_in(cfg_addr_in), .cfg_wdata_in(cfg_wdata_in), .cfg_rdata_out(cfg_rdata_out),
        .ext_card_mode_in(ext_card_mode_in), .top_of_memory_in(top_of_memory_in), .acc_valid_in(acc_valid_in),
        .acc_in(acc_in), .ans_valid_out(ans_valid_out), .ans_out(ans_out), .gfx_enable_out(gfx_enable_out),
        .gfx_clk_en_out(gfx_clk_en_out), .sysram_top_out(sysram_top_out), .gfx_base_out(gfx_base_out),
        .top_segment_base_out(top_segment_base_out), .dram_regs_locked_out(dram_regs_locked_out));

    // free-running clock, 10 ns period
    initial begin
        forever #5 clk_in = ~clk_in;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic do_reset(input int n);
        @(negedge clk_in);
        sys_rst_in = 1'b1;
        repeat (n) @(negedge clk_in);
        sys_rst_in = 1'b0;
    endtask

    task automatic cfg_write(input logic [7:0] off, input logic [7:0] d);
        @(negedge clk_in);
        cfg_wr_in = 1'b1;
        cfg_addr_in = off;
        cfg_wdata_in = d;
        @(negedge clk_in);
        cfg_wr_in = 1'b0;
        cfg_wdata_in = ~d;
    endtask

    // read data is registered, so it is looked at one edge after the strobe
    task automatic cfg_read(input logic [7:0] off, input logic [7:0] exp);
        @(negedge clk_in);
        cfg_rd_in = 1'b1;
        cfg_addr_in = off;
        @(negedge clk_in);
        cfg_rd_in = 1'b0;
        chk("cfg_rdata", {24'h0, exp}, {24'h0, cfg_rdata_out});
    endtask

    task automatic acc(input logic [31:0] a, input logic wr, input logic code, input logic smm, input logic wb,
                       input route_t rt, input logic [31:0] da);
        u_host_cpu_model.issue({a, wr, code, smm, 1'b1, wb});
        chk("ans_valid", 32'h1, {31'h0, ans_valid_out});
        chk("route", {29'h0, rt}, {29'h0, ans_out.route});
        if (rt == ROUTE_DRAM) chk("dram_addr", da, ans_out.dram_addr);
    endtask

    task automatic sc_reset_state();
        cfg_read(8'h70, 8'h00);
        chk("gfx_enable", 32'h0, {31'h0, gfx_enable_out});
        chk("top_seg_base", TOP_OF_MEMORY, top_segment_base_out);
        cfg_write(8'h71, 8'hff);
        cfg_read(8'h71, 8'h00);
        cfg_read(8'h70, 8'h00);
    endtask

    // every graphics code, then the same codes under external card mode
    task automatic sc_gfx_codes();
        logic [31:0] sz;
        for (int m = 0; m < 2; m++) begin
            ext_card_mode_in = m[0];
            for (int g = 0; g < 4; g++) begin
                sz = (g == 2) ? 32'h0008_0000 : (g == 3) ? 32'h0010_0000 : 32'h0;
                cfg_write(8'h70, {g[1:0], 6'h0});
                cfg_read(8'h70, {g[1:0], 6'h0});
                chk("gfx_enable", {31'h0, g != 0 && m == 0}, {31'h0, gfx_enable_out});
                chk("gfx_clk_en", {31'h0, g != 0 && m == 0}, {31'h0, gfx_clk_en_out});
                chk("gfx_base", (m == 0) ? TOP_OF_MEMORY - sz : TOP_OF_MEMORY, gfx_base_out);
            end
        end
        ext_card_mode_in = 1'b0;
        // top segment carved first, graphics just below
        cfg_write(8'h70, 8'he0);
        cfg_read(8'h70, 8'he0);
        chk("top_seg_base", TOP_OF_MEMORY - 32'h0008_0000, top_segment_base_out);
        chk("gfx_base", TOP_OF_MEMORY - 32'h0018_0000, gfx_base_out);
        chk("sysram_top", TOP_OF_MEMORY - 32'h0018_0000, sysram_top_out);
        acc(TOP_OF_MEMORY - 32'h0018_0000, 1'b0, 1'b0, 1'b0, 1'b0, ROUTE_HUB, 32'h0);
    endtask

    // A/B segment: smm code read, smm data write, normal write for each lower code
    task automatic sc_lower_seg();
        logic [2:0] dram_mask;
        route_t     other;
        for (int g = 0; g < 2; g++) begin
            other = g ? ROUTE_GFX : ROUTE_HUB;
            for (int l = 0; l < 4; l++) begin
                dram_mask = (l == 1) ? 3'b111 : (l == 2) ? 3'b100 : (l == 3) ? 3'b110 : 3'b000;
                cfg_write(8'h70, {g[0], 1'b0, 2'b00, l[1:0], 2'b00});
                acc(32'h000a_0010, 1'b0, 1'b1, 1'b1, 1'b0, dram_mask[2] ? ROUTE_DRAM : other, 32'h000a_0010);
                acc(32'h000b_fff0, 1'b1, 1'b0, 1'b1, 1'b0, dram_mask[1] ? ROUTE_DRAM : other, 32'h000b_fff0);
                acc(32'h000a_8000, 1'b1, 1'b0, 1'b0, 1'b0, dram_mask[0] ? ROUTE_DRAM : other, 32'h000a_8000);
            end
        end
        acc(32'h000c_0000, 1'b0, 1'b0, 1'b0, 1'b0, ROUTE_DRAM, 32'h000c_0000);
    endtask

    // upper segments, error flag set and clear
    task automatic sc_upper_seg();
        // fill the top segment while it is still plain RAM, then close it
        cfg_write(8'h70, 8'h00);
        acc(TOP_OF_MEMORY - 32'h0000_0010, 1'b1, 1'b0, 1'b0, 1'b0, ROUTE_DRAM, TOP_OF_MEMORY - 32'h0000_0010);
        cfg_write(8'h70, 8'h30);
        acc(TOP_OF_MEMORY - 32'h0010_0000, 1'b1, 1'b0, 1'b1, 1'b0, ROUTE_DRAM, TOP_OF_MEMORY - 32'h0010_0000);
        acc(TOP_OF_MEMORY - 32'h0010_0001, 1'b0, 1'b0, 1'b0, 1'b0, ROUTE_DRAM, TOP_OF_MEMORY - 32'h0010_0001);
        cfg_read(8'h70, 8'h30);
        acc(TOP_OF_MEMORY - 32'h0000_0010, 1'b1, 1'b0, 1'b0, 1'b1, ROUTE_HUB, 32'h0);
        cfg_read(8'h70, 8'h30);
        acc(TOP_OF_MEMORY - 32'h0000_0010, 1'b0, 1'b0, 1'b0, 1'b0, ROUTE_HUB, 32'h0);
        cfg_read(8'h70, 8'h31);
        // software clears the flag by writing one; zero leaves it
        cfg_write(8'h70, 8'h30);
        cfg_read(8'h70, 8'h31);
        cfg_write(8'h70, 8'h31);
        cfg_read(8'h70, 8'h30);
        acc(32'hfeea_0010, 1'b0, 1'b0, 1'b1, 1'b0, ROUTE_DRAM, 32'h000a_0010);
        acc(32'hfeeb_fff0, 1'b0, 1'b0, 1'b0, 1'b0, ROUTE_HUB, 32'h0);
        cfg_read(8'h70, 8'h31);
        cfg_write(8'h70, 8'h3d);
        acc(32'hfeea_0010, 1'b0, 1'b0, 1'b0, 1'b0, ROUTE_HUB, 32'h0);
        cfg_read(8'h70, 8'h3c);
    endtask

    task automatic sc_lock();
        cfg_write(8'h70, 8'h36);
        cfg_write(8'h70, 8'hc8);
        cfg_read(8'h70, 8'h36);
        chk("dram_locked", 32'h1, {31'h0, dram_regs_locked_out});
        do_reset(2);
        cfg_read(8'h70, 8'h00);
        chk("dram_locked", 32'h0, {31'h0, dram_regs_locked_out});
        cfg_write(8'h70, 8'h0e);
        cfg_write(8'h70, 8'h08);
        cfg_read(8'h70, 8'h0a);
        do_reset(2);
    endtask

    // run limit: a hang counts as a mismatch
    initial begin
        #200us;
        num_errors++;
        $display("Error watchdog expected finish seen hang");
        give_verdict();
    end

    initial begin
        do_reset(8);
        sc_reset_state();
        sc_gfx_codes();
        sc_lower_seg();
        sc_upper_seg();
        sc_lock();
        give_verdict();
    end
endmodule // tb_top

`default_nettype wire
